// file: verilog/usp_pkg.sv
/*
 * usp_pkg: constants, field positions, reset values, bus carrier and
 * state types for the uart shadow receive/transmit port.
 * assumes a 32-bit word-aligned register bus and a single system clock.
 */
package usp_pkg;

    // ------------------------------------------------------------------
    // fifo geometry
    // ------------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_ONE = 5'h01;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
    localparam logic [31:0] ALIAS_LAST = 32'h5000_106C;
    localparam logic [31:0] RX_TX_SHADOW_ALIAS_8 = 32'h5000_1050;
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1080;
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1084;
    localparam logic [31:0] DIVISOR_ADDR = 32'h5000_1088;
    localparam logic [31:0] INT_STATUS_ADDR = 32'h5000_108C;
    localparam logic [31:0] INT_CLEAR_ADDR = 32'h5000_1090;
    localparam logic [31:0] INT_ENABLE_ADDR = 32'h5000_1094;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_FIFO_EN_BIT = 0;
    localparam int unsigned CTRL_IR_MODE_BIT = 1;
    localparam int unsigned LS_DATA_READY_BIT = 0;
    localparam int unsigned LS_OVERRUN_BIT = 1;
    localparam int unsigned LS_TX_EMPTY_BIT = 5;
    localparam int unsigned LS_TX_FULL_BIT = 6;
    localparam int unsigned INT_RX_BIT = 0;
    localparam int unsigned INT_TX_EMPTY_BIT = 1;
    localparam int unsigned INT_OVERRUN_BIT = 2;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] DIVISOR_RESET = 16'h06C8;
    localparam logic [15:0] DIVISOR_MIN = 16'h0001;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } usp_bus_req_t;

    typedef enum logic [3:0] {
        SER_IDLE = 4'h1,
        SER_START = 4'h2,
        SER_DATA = 4'h4,
        SER_STOP = 4'h8
    } usp_ser_state_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic irq;
        logic sout;
        logic sir_out_n;
        logic data_ready;
        logic tx_empty;
        logic fifo_en;
        logic ir_mode;
        logic overrun;
        logic [15:0] divisor;
        logic [2:0] int_status;
        logic [2:0] int_enable;
        logic [FIFO_DEPTH-1:0][7:0] rx_mem;
        logic [3:0] rx_wr;
        logic [3:0] rx_rd;
        logic [4:0] rx_cnt;
        logic [FIFO_DEPTH-1:0][7:0] tx_mem;
        logic [3:0] tx_wr;
        logic [3:0] tx_rd;
        logic [4:0] tx_cnt;
        usp_ser_state_t rx_st;
        logic [15:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        usp_ser_state_t tx_st;
        logic [15:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_shift;
        logic tx_line;
    } usp_state_t;

endpackage

// file: verilog/usp_shadow_port.sv
/*
 * usp_shadow_port: shadow receive/transmit buffer port of a uart, with
 * receive and transmit fifos, 8n1 serial engine, ir line select,
 * line status and interrupt registers.
 * assumes inputs synchronous to sys_clk and a master that never waits.
 */
`timescale 1ns/1ps

module usp_shadow_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire usp_pkg::usp_bus_req_t bus,
    output logic [31:0] rdata,
    // serial lines
    input wire logic sin,
    input wire logic sir_in,
    output logic sout,
    output logic sir_out_n,
    // status and interrupt
    output logic data_ready_flag,
    output logic tx_holding_empty,
    output logic irq
);

    usp_pkg::usp_state_t s;
    usp_pkg::usp_state_t n;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic rx_line;
        logic [15:0] div;
        logic alias_hit;
        logic rx_push;
        logic [2:0] events;
        rx_line = 1'b1;
        div = usp_pkg::DIVISOR_MIN;
        alias_hit = 1'b0;
        rx_push = 1'b0;
        events = 3'h0;
        n = s;
        n.rdata = 32'h0000_0000;
        // ir input idles low and pulses high for a zero bit
        rx_line = s.ir_mode ? ~sir_in : sin;
        // zero divisor would never tick
        div = (s.divisor == 16'h0000) ? usp_pkg::DIVISOR_MIN : s.divisor;
        alias_hit = (bus.addr >= usp_pkg::ALIAS_BASE) && (bus.addr <= usp_pkg::ALIAS_LAST)
            && (bus.addr[1:0] == 2'b00);

        // --------------------------------------------------------------
        // transmit engine, pops before the bus write so both fit a cycle
        // --------------------------------------------------------------
        case (s.tx_st)
            usp_pkg::SER_IDLE: begin
                if (s.tx_cnt != 5'h00) begin
                    n.tx_shift = s.tx_mem[s.tx_rd];
                    n.tx_rd = s.tx_rd + 4'h1;
                    n.tx_cnt = s.tx_cnt - usp_pkg::CNT_ONE;
                    n.tx_line = 1'b0;
                    n.tx_tick = div - 16'h0001;
                    n.tx_st = usp_pkg::SER_START;
                end
            end
            usp_pkg::SER_START: begin
                if (s.tx_tick == 16'h0000) begin
                    n.tx_line = s.tx_shift[0];
                    n.tx_bit = 3'h0;
                    n.tx_tick = div - 16'h0001;
                    n.tx_st = usp_pkg::SER_DATA;
                end else begin
                    n.tx_tick = s.tx_tick - 16'h0001;
                end
            end
            usp_pkg::SER_DATA: begin
                if (s.tx_tick == 16'h0000) begin
                    n.tx_tick = div - 16'h0001;
                    n.tx_shift = {1'b0, s.tx_shift[7:1]};
                    if (s.tx_bit == 3'h7) begin
                        n.tx_line = 1'b1;
                        n.tx_st = usp_pkg::SER_STOP;
                    end else begin
                        n.tx_line = s.tx_shift[1];
                        n.tx_bit = s.tx_bit + 3'h1;
                    end
                end else begin
                    n.tx_tick = s.tx_tick - 16'h0001;
                end
            end
            usp_pkg::SER_STOP: begin
                if (s.tx_tick == 16'h0000) begin
                    n.tx_st = usp_pkg::SER_IDLE;
                end else begin
                    n.tx_tick = s.tx_tick - 16'h0001;
                end
            end
            default: begin
                n.tx_st = usp_pkg::SER_IDLE;
                n.tx_line = 1'b1;
            end
        endcase

        // --------------------------------------------------------------
        // bus reads
        // --------------------------------------------------------------
        if (bus.rd) begin
            if (alias_hit) begin
                // head of the fifo; with fifos off the single holding entry
                n.rdata = {24'h00_0000, s.rx_mem[s.rx_rd]};
                if (s.rx_cnt != 5'h00) begin
                    n.rx_rd = s.rx_rd + 4'h1;
                    n.rx_cnt = s.rx_cnt - usp_pkg::CNT_ONE;
                end
            end else if (bus.addr == usp_pkg::CTRL_ADDR) begin
                n.rdata[usp_pkg::CTRL_FIFO_EN_BIT] = s.fifo_en;
                n.rdata[usp_pkg::CTRL_IR_MODE_BIT] = s.ir_mode;
            end else if (bus.addr == usp_pkg::LINE_STATUS_ADDR) begin
                n.rdata[usp_pkg::LS_DATA_READY_BIT] = s.data_ready;
                n.rdata[usp_pkg::LS_OVERRUN_BIT] = s.overrun;
                n.rdata[usp_pkg::LS_TX_EMPTY_BIT] = s.tx_empty;
                n.rdata[usp_pkg::LS_TX_FULL_BIT] = (s.tx_cnt == usp_pkg::CNT_FULL);
                // overrun clears on read of line status
                n.overrun = 1'b0;
            end else if (bus.addr == usp_pkg::DIVISOR_ADDR) begin
                n.rdata[15:0] = s.divisor;
            end else if (bus.addr == usp_pkg::INT_STATUS_ADDR) begin
                n.rdata[2:0] = s.int_status;
            end else if (bus.addr == usp_pkg::INT_ENABLE_ADDR) begin
                n.rdata[2:0] = s.int_enable;
            end
        end

        // --------------------------------------------------------------
        // bus writes
        // --------------------------------------------------------------
        if (bus.wr) begin
            if (alias_hit) begin
                if (!s.fifo_en) begin
                    // single holding entry: overwrite whatever is pending
                    n.tx_mem[n.tx_rd] = bus.wdata[7:0];
                    n.tx_wr = n.tx_rd + 4'h1;
                    n.tx_cnt = usp_pkg::CNT_ONE;
                end else if (n.tx_cnt != usp_pkg::CNT_FULL) begin
                    n.tx_mem[s.tx_wr] = bus.wdata[7:0];
                    n.tx_wr = s.tx_wr + 4'h1;
                    n.tx_cnt = n.tx_cnt + usp_pkg::CNT_ONE;
                end
            end else if (bus.addr == usp_pkg::CTRL_ADDR) begin
                n.ir_mode = bus.wdata[usp_pkg::CTRL_IR_MODE_BIT];
                n.fifo_en = bus.wdata[usp_pkg::CTRL_FIFO_EN_BIT];
                if (n.fifo_en != s.fifo_en) begin
                    // fifo mode change flushes both sides, as depth changes
                    n.rx_wr = 4'h0;
                    n.rx_rd = 4'h0;
                    n.rx_cnt = 5'h00;
                    n.tx_wr = 4'h0;
                    n.tx_rd = 4'h0;
                    n.tx_cnt = 5'h00;
                end
            end else if (bus.addr == usp_pkg::DIVISOR_ADDR) begin
                n.divisor = bus.wdata[15:0];
            end else if (bus.addr == usp_pkg::INT_CLEAR_ADDR) begin
                n.int_status = s.int_status & ~bus.wdata[2:0];
            end else if (bus.addr == usp_pkg::INT_ENABLE_ADDR) begin
                n.int_enable = bus.wdata[2:0];
            end
        end

        // --------------------------------------------------------------
        // receive engine, 8n1 sampled at mid bit
        // --------------------------------------------------------------
        case (s.rx_st)
            usp_pkg::SER_IDLE: begin
                if (!rx_line) begin
                    // low edge is seen one cycle late, so wait half a bit less one
                    n.rx_tick = (div[15:1] == 15'h0000) ? 16'h0000 : ({1'b0, div[15:1]} - 16'h0001);
                    n.rx_st = usp_pkg::SER_START;
                end
            end
            usp_pkg::SER_START: begin
                if (s.rx_tick == 16'h0000) begin
                    n.rx_tick = div - 16'h0001;
                    n.rx_bit = 3'h0;
                    // glitch shorter than half a bit is no start
                    n.rx_st = rx_line ? usp_pkg::SER_IDLE : usp_pkg::SER_DATA;
                end else begin
                    n.rx_tick = s.rx_tick - 16'h0001;
                end
            end
            usp_pkg::SER_DATA: begin
                if (s.rx_tick == 16'h0000) begin
                    n.rx_tick = div - 16'h0001;
                    n.rx_shift = {rx_line, s.rx_shift[7:1]};
                    n.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == 3'h7) begin
                        n.rx_st = usp_pkg::SER_STOP;
                    end
                end else begin
                    n.rx_tick = s.rx_tick - 16'h0001;
                end
            end
            usp_pkg::SER_STOP: begin
                if (s.rx_tick == 16'h0000) begin
                    // a bad stop bit drops the character silently
                    rx_push = rx_line;
                    n.rx_st = usp_pkg::SER_IDLE;
                end else begin
                    n.rx_tick = s.rx_tick - 16'h0001;
                end
            end
            default: begin
                n.rx_st = usp_pkg::SER_IDLE;
            end
        endcase

        if (rx_push) begin
            events[usp_pkg::INT_RX_BIT] = 1'b1;
            if (!n.fifo_en && (n.rx_cnt != 5'h00)) begin
                n.rx_mem[n.rx_rd] = s.rx_shift;
                events[usp_pkg::INT_OVERRUN_BIT] = 1'b1;
            end else if (n.rx_cnt == usp_pkg::CNT_FULL) begin
                events[usp_pkg::INT_OVERRUN_BIT] = 1'b1;
            end else begin
                n.rx_mem[n.rx_wr] = s.rx_shift;
                n.rx_wr = n.rx_wr + 4'h1;
                n.rx_cnt = n.rx_cnt + usp_pkg::CNT_ONE;
            end
        end

        // --------------------------------------------------------------
        // status, interrupt and line outputs; set wins over clear
        // --------------------------------------------------------------
        if (events[usp_pkg::INT_OVERRUN_BIT]) begin
            n.overrun = 1'b1;
        end
        events[usp_pkg::INT_TX_EMPTY_BIT] = (n.tx_cnt == 5'h00) && !s.tx_empty;
        n.int_status = n.int_status | events;
        n.irq = |(n.int_status & n.int_enable);
        n.data_ready = (n.rx_cnt != 5'h00);
        n.tx_empty = (n.tx_cnt == 5'h00);
        n.sout = n.ir_mode ? 1'b1 : n.tx_line;
        n.sir_out_n = n.ir_mode ? n.tx_line : 1'b1;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s <= '0;
            s.sout <= 1'b1;
            s.sir_out_n <= 1'b1;
            s.tx_line <= 1'b1;
            s.tx_empty <= 1'b1;
            s.divisor <= usp_pkg::DIVISOR_RESET;
            s.rx_st <= usp_pkg::SER_IDLE;
            s.tx_st <= usp_pkg::SER_IDLE;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign sout = s.sout;
    assign sir_out_n = s.sir_out_n;
    assign data_ready_flag = s.data_ready;
    assign tx_holding_empty = s.tx_empty;
    assign irq = s.irq;

endmodule

// file: test/usp_shadow_port_checker.sv
/*
 * usp_shadow_port_checker: port-level assertions for the shadow port.
 * assumes one clock domain, bound to every usp_shadow_port instance.
 */
`timescale 1ns/1ps

module usp_shadow_port_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire usp_pkg::usp_bus_req_t bus,
    input wire logic [31:0] rdata,
    // serial lines
    input wire logic sin,
    input wire logic sir_in,
    input wire logic sout,
    input wire logic sir_out_n,
    // status
    input wire logic data_ready_flag,
    input wire logic tx_holding_empty,
    input wire logic irq
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    logic is_alias;
    logic ctrl_wr;
    assign is_alias = bus.addr >= usp_pkg::ALIAS_BASE && bus.addr <= usp_pkg::ALIAS_LAST && bus.addr[1:0] == 2'h0;
    assign ctrl_wr = bus.wr && bus.addr == usp_pkg::CTRL_ADDR;
    // mode copy from control writes, so the stop-bit check looks at the live line only
    logic ir_seen;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ir_seen <= 1'b0;
        end else if (ctrl_wr) begin
            ir_seen <= bus.wdata[usp_pkg::CTRL_IR_MODE_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_rd_idle; !bus.rd |=> rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_upper_zero; bus.rd && is_alias |=> rdata[31:8] == 24'h0; endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper alias bits not zero");
    property p_tx_clear; bus.wr && is_alias |=> !tx_holding_empty; endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("empty flag kept after write");
    property p_tx_hold; tx_holding_empty && !bus.wr |=> tx_holding_empty; endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("empty flag dropped without write");
    property p_tx_rise; $rose(tx_holding_empty) |-> !$past(bus.wr && is_alias); endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("empty flag set by a write");
    property p_dr_fall; $fell(data_ready_flag) |-> $past(bus.rd && is_alias) || $past(ctrl_wr); endproperty
    a_dr_fall: assert property (p_dr_fall) else $error("data ready lost without read");
    property p_dr_rise; $rose(data_ready_flag) |-> ($past(ir_seen) ? !$past(sir_in) : $past(sin)); endproperty
    a_dr_rise: assert property (p_dr_rise) else $error("character stored without stop bit");
    property p_ir_out; !sir_out_n |-> sout; endproperty
    a_ir_out: assert property (p_ir_out) else $error("both serial outputs active");
endmodule

bind usp_shadow_port usp_shadow_port_checker i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .sin(sin), .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .data_ready_flag(data_ready_flag),
    .tx_holding_empty(tx_holding_empty), .irq(irq));

// file: test/usp_serial_peer.sv
/*
 * usp_serial_peer: remote 8n1 peer, sends on sin or sir_in, collects
 * characters from sout or sir_out_n into rx_q.
 * assumes divisor and ir mode match the block's settings.
 */
`timescale 1ns/1ps

module usp_serial_peer (
    // clock and mode
    input wire logic sys_clk,
    input wire logic ir_mode,
    input wire logic [15:0] div,
    // lines from the block
    input wire logic sout,
    input wire logic sir_out_n,
    // lines to the block
    output logic sin,
    output logic sir_in
);
    logic [7:0] rx_q[$];
    logic line;
    assign line = ir_mode ? sir_out_n : sout;
    // idle: sin pulled high, ir line dark
    initial begin
        sin = 1'b1;
        sir_in = 1'b0;
    end

    task automatic put_bit(input logic b);
        sin <= ir_mode ? 1'b1 : b;
        sir_in <= ir_mode ? ~b : 1'b0;
        repeat (div) @(posedge sys_clk);
    endtask

    task automatic send(input logic [7:0] c);
        @(posedge sys_clk);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) put_bit(c[i]);
        put_bit(1'b1);
    endtask

    // ------------------------------------------------------------------
    // receiver, sampled on falling edge to stay clear of output updates
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] c;
        forever begin
            @(negedge sys_clk);
            if (!line) begin
                repeat (div / 2) @(negedge sys_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (div) @(negedge sys_clk);
                    c[i] = line;
                end
                repeat (div) @(negedge sys_clk);
                rx_q.push_back(c);
            end
        end
    end
endmodule

// file: test/usp_shadow_port_tb_top.sv
/*
 * usp_shadow_port_tb_top: register-level tests of the shadow port.
 * assumes the serial peer model and the bound checker.
 */
`timescale 1ns/1ps

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module usp_shadow_port_tb_top;
    logic sys_clk, reset_n, ir_mode, sin, sir_in, sout, sir_out_n, data_ready_flag, tx_holding_empty, irq;
    logic [15:0] div;
    logic [31:0] rdata, rd_val;
    logic [7:0] c;
    usp_pkg::usp_bus_req_t bus;
    int err_total, total_checks;

    usp_shadow_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .sin(sin),
        .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .data_ready_flag(data_ready_flag),
        .tx_holding_empty(tx_holding_empty), .irq(irq));
    usp_serial_peer i_peer (.sys_clk(sys_clk), .ir_mode(ir_mode), .div(div), .sout(sout),
        .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // bus and wait tasks
    // ------------------------------------------------------------------
    task stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{a, d, 1'b1, 1'b0};
    endtask
    task idle;
        @(posedge sys_clk);
        bus <= '0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge sys_clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        idle();
        #1 rd_val = rdata;
    endtask
    task chk_tx(input logic [7:0] e);
        int k;
        k = 0;
        while (i_peer.rx_q.size() == 0 && k < 3000) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 3000) begin
            err_total++;
            stop_test();
        end
        c = i_peer.rx_q.pop_front();
        `CHK("tx char", e, c)
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        bus = '0;
        ir_mode = 1'b0;
        div = 16'h0004;
        reset_n = 1'b0;
        err_total = 0;
        total_checks = 0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 `CHK("reset empty", 1'b1, tx_holding_empty)
        rd(usp_pkg::RX_TX_SHADOW_ALIAS_8);
        `CHK("alias reset", 32'h0, rd_val)
        rd(usp_pkg::DIVISOR_ADDR);
        `CHK("divisor reset", {16'h0000, usp_pkg::DIVISOR_RESET}, rd_val)
        rd(32'h5000_10FC);
        `CHK("unmapped", 32'h0, rd_val)
        wr(usp_pkg::DIVISOR_ADDR, 32'h4);
        idle();
        rd(usp_pkg::DIVISOR_ADDR);
        `CHK("divisor", 32'h4, rd_val)
        // fifos off: receive, then overrun
        i_peer.send(8'hA5);
        #1 `CHK("ready", 1'b1, data_ready_flag)
        rd(usp_pkg::RX_TX_SHADOW_ALIAS_8);
        `CHK("rx byte", 32'hA5, rd_val)
        i_peer.send(8'h3C);
        i_peer.send(8'h5A);
        rd(usp_pkg::RX_TX_SHADOW_ALIAS_8);
        `CHK("rx newest", 32'h5A, rd_val)
        rd(usp_pkg::LINE_STATUS_ADDR);
        `CHK("overrun", 1'b1, rd_val[1])
        // fifos off: pending character overwritten, upper bits ignored
        wr(usp_pkg::RX_TX_SHADOW_ALIAS_8, 32'hFFFF_FF11);
        wr(usp_pkg::ALIAS_BASE, 32'h22);
        wr(usp_pkg::ALIAS_LAST, 32'h33);
        idle();
        chk_tx(8'h11);
        chk_tx(8'h33);
        // fifos on: fill receive fifo past depth, drain through all aliases
        wr(usp_pkg::CTRL_ADDR, 32'h1);
        idle();
        for (int i = 0; i < 17; i++) i_peer.send(8'(8'h80 + i));
        rd(usp_pkg::LINE_STATUS_ADDR);
        `CHK("fifo overrun", 1'b1, rd_val[1])
        for (int i = 0; i < 16; i++) begin
            rd(usp_pkg::ALIAS_BASE + 32'(4 * i));
            `CHK("rx fifo", {24'h0, 8'(8'h80 + i)}, rd_val)
        end
        `CHK("drained", 1'b0, data_ready_flag)
        // fifos on: burst of 18 writes, last one must be lost
        `CHK("empty before burst", 1'b1, tx_holding_empty)
        for (int i = 0; i < 18; i++) wr(usp_pkg::ALIAS_BASE + 32'(4 * (i % 16)), 32'(8'hC0 + i));
        idle();
        rd(usp_pkg::LINE_STATUS_ADDR);
        `CHK("tx full", 1'b1, rd_val[6])
        for (int i = 0; i < 17; i++) chk_tx(8'(8'hC0 + i));
        repeat (60) @(posedge sys_clk);
        `CHK("dropped", 0, i_peer.rx_q.size())
        // ir mode both ways
        ir_mode <= 1'b1;
        wr(usp_pkg::CTRL_ADDR, 32'h3);
        idle();
        rd(usp_pkg::CTRL_ADDR);
        `CHK("ctrl", 32'h3, rd_val)
        i_peer.send(8'h6E);
        rd(usp_pkg::RX_TX_SHADOW_ALIAS_8);
        `CHK("ir rx", 32'h6E, rd_val)
        wr(usp_pkg::RX_TX_SHADOW_ALIAS_8, 32'h9B);
        idle();
        chk_tx(8'h9B);
        ir_mode <= 1'b0;
        wr(usp_pkg::CTRL_ADDR, 32'h0);
        // interrupt: masked, enabled, cleared
        wr(usp_pkg::INT_ENABLE_ADDR, 32'h0);
        wr(usp_pkg::INT_CLEAR_ADDR, 32'h7);
        idle();
        i_peer.send(8'h01);
        #1 `CHK("irq masked", 1'b0, irq)
        rd(usp_pkg::INT_STATUS_ADDR);
        `CHK("rx event", 1'b1, rd_val[0])
        wr(usp_pkg::INT_ENABLE_ADDR, 32'h1);
        idle();
        idle();
        #1 `CHK("irq on", 1'b1, irq)
        rd(usp_pkg::INT_ENABLE_ADDR);
        `CHK("int enable", 32'h1, rd_val)
        wr(usp_pkg::INT_CLEAR_ADDR, 32'h1);
        idle();
        idle();
        #1 `CHK("irq cleared", 1'b0, irq)
        stop_test();
    end
endmodule
